// ---- vtp_pkg.sv ----
// Constants and types shared by the vectored trap prioritizer
package vtp_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int TRAP_W = 5;
	localparam int NUM_MASKABLE = 14;
	localparam int BIT_W = 4;
	localparam int BASE_W = 9;
	localparam int OFS_W = 7;
	localparam int ADDR_W = 16;
	localparam int NUM_PINS = 5;

	// ------------------------------------------------------------
	// Trap numbers
	// ------------------------------------------------------------
	localparam logic [TRAP_W-1:0] TRAP_RESET = 5'h00;
	localparam logic [TRAP_W-1:0] TRAP_NMI = 5'h01;
	localparam logic [TRAP_W-1:0] TRAP_SW_LO = 5'h02;
	localparam logic [TRAP_W-1:0] TRAP_SW_HI = 5'h0f;
	localparam logic [TRAP_W-1:0] TRAP_MASK_BASE = 5'h10;
	localparam logic [TRAP_W-1:0] TRAP_RSV_LO = 5'h1e;

	// Vector offset is trap number shifted by this many bits
	localparam int VEC_SHIFT = 2;

	// ------------------------------------------------------------
	// Flag and mask bit positions (trap number minus 16)
	// ------------------------------------------------------------
	localparam int BIT_EXT0 = 0;
	localparam int BIT_EXT1 = 1;
	localparam int BIT_EXT2 = 2;
	localparam int BIT_TIMER = 3;
	localparam int BIT_SP0_RX = 4;
	localparam int BIT_SP0_TX = 5;
	localparam int BIT_SP2_RX = 6;
	localparam int BIT_SP2_TX = 7;
	localparam int BIT_EXT3 = 8;
	localparam int BIT_HOST = 9;
	localparam int BIT_SP1_RX = 10;
	localparam int BIT_SP1_TX = 11;
	localparam int BIT_DMA4 = 12;
	localparam int BIT_DMA5 = 13;

	// Pin edge detector lanes
	localparam int PIN_NMI = 4;

	localparam logic [NUM_MASKABLE-1:0] FLAGS_RESET = 14'h0000;
	localparam logic [NUM_MASKABLE-1:0] MASK_RESET = 14'h0000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_OFFER = 2'b10
	} vtp_state_t;

	typedef enum logic [3:0] {
		SRC_RESET = 4'b0001,
		SRC_NMI   = 4'b0010,
		SRC_SW    = 4'b0100,
		SRC_MASK  = 4'b1000
	} vtp_src_t;

endpackage

// ---- vtp_req_if.sv ----
// Request and grant bundle between the trap selector and its encoder
`timescale 1ns/100ps
interface vtp_req_if;
	logic [vtp_pkg::NUM_MASKABLE-1:0] req;
	logic [vtp_pkg::BIT_W-1:0]        idx;
	logic                             any;

	modport enc (
		input  req,
		output idx,
		output any
	);

	modport user (
		output req,
		input  idx,
		input  any
	);
endinterface

// ---- vtp_pin_edge.sv ----
// Two-stage synchroniser with falling-edge detect for active-low pins
`timescale 1ns/100ps
module vtp_pin_edge #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pin_n,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;

	// Idle level of an active-low pin is high
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_q <= {WIDTH{1'b1}};
			sync_q <= {WIDTH{1'b1}};
			prev_q <= {WIDTH{1'b1}};
		end else begin
			meta_q <= pin_n;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign fall = prev_q & ~sync_q;
endmodule

// ---- vtp_prio_enc.sv ----
// Fixed-priority encoder: the lowest set bit wins
`timescale 1ns/100ps
module vtp_prio_enc (
	vtp_req_if.enc bus
);
	always_comb begin
		bus.idx = '0;
		bus.any = 1'b0;
		for (int i = vtp_pkg::NUM_MASKABLE - 1; i >= 0; i--) begin
			if (bus.req[i]) begin
				bus.idx = i[vtp_pkg::BIT_W-1:0];
				bus.any = 1'b1;
			end
		end
	end
endmodule

// ---- vtp_trap_prioritizer.sv ----
// Trap vector generation and fixed-priority interrupt selection
`timescale 1ns/100ps

// Notes on behaviour
// (R1) Vector offset is four times trap number
// (R2) Trap 0 serves both resets, highest priority
// (R3) External line 0: trap 16, priority 3
// (R4) External line 1: trap 17, priority 4
// (R5) External line 2: trap 18, priority 5
// (R6) External line 3: trap 24, priority 11
// (R7) Serial 0 receive: trap 20, priority 7
// (R8) Serial 0 transmit: trap 21, priority 8
// (R9) Serial 2 receive: trap 22, priority 9
// (R10) Serial 2 transmit: trap 23, priority 10
// (R11) Serial 1 receive: trap 26, priority 13
// (R12) Serial 1 transmit: trap 27, priority 14
// (R13) DMA channel 4: trap 28, priority 15
// (R14) DMA channel 5: trap 29, lowest priority
// (R15) Flag and mask share one bit layout
// (R16) NMI trap 1, timer 19, host 25
// (R17) Traps 2-15 software only; 30-31 reserved
// (R18) Bit is trap minus 16; mask gates
module vtp_trap_prioritizer (
	input  wire logic                              clk_sys,
	input  wire logic                              rst,
	input  wire logic [3:0]                        extLine_n,
	input  wire logic                              nmi_n,
	input  wire logic                              timerEvt,
	input  wire logic                              sp0RxEvt,
	input  wire logic                              sp0TxEvt,
	input  wire logic                              sp1RxEvt,
	input  wire logic                              sp1TxEvt,
	input  wire logic                              sp2RxEvt,
	input  wire logic                              sp2TxEvt,
	input  wire logic                              hostEvt,
	input  wire logic                              dma4Evt,
	input  wire logic                              dma5Evt,
	input  wire logic                              softResetReq,
	input  wire logic                              swTrapReq,
	input  wire logic [vtp_pkg::TRAP_W-1:0]        swTrapNum,
	input  wire logic                              intEnable,
	input  wire logic                              maskWrEn,
	input  wire logic [vtp_pkg::NUM_MASKABLE-1:0]  maskWrData,
	input  wire logic [vtp_pkg::NUM_MASKABLE-1:0]  flagClr,
	input  wire logic [vtp_pkg::BASE_W-1:0]        vecBase,
	input  wire logic                              trapAck,
	output logic                                   trapReq,
	output logic      [vtp_pkg::TRAP_W-1:0]        trapNum,
	output logic      [vtp_pkg::ADDR_W-1:0]        trapVector,
	output logic      [vtp_pkg::NUM_MASKABLE-1:0]  pendingFlags,
	output logic      [vtp_pkg::NUM_MASKABLE-1:0]  maskBits
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [vtp_pkg::NUM_PINS-1:0] pinFall;

	// NMI rides the top lane, beside the four external lines
	vtp_pin_edge #(
		.WIDTH (vtp_pkg::NUM_PINS)
	) uPins (
		.clk_sys (clk_sys),
		.rst     (rst),
		.pin_n   ({nmi_n, extLine_n}),
		.fall    (pinFall)
	);

	// ------------------------------------------------------------
	// Maskable event map
	// ------------------------------------------------------------
	logic [vtp_pkg::NUM_MASKABLE-1:0] evtVec;

	always_comb begin
		evtVec = '0;
		evtVec[vtp_pkg::BIT_EXT0] = pinFall[0]; // R3
		evtVec[vtp_pkg::BIT_EXT1] = pinFall[1]; // R4
		evtVec[vtp_pkg::BIT_EXT2] = pinFall[2]; // R5
		evtVec[vtp_pkg::BIT_TIMER] = timerEvt; // R16
		evtVec[vtp_pkg::BIT_SP0_RX] = sp0RxEvt; // R7
		evtVec[vtp_pkg::BIT_SP0_TX] = sp0TxEvt; // R8
		evtVec[vtp_pkg::BIT_SP2_RX] = sp2RxEvt; // R9
		evtVec[vtp_pkg::BIT_SP2_TX] = sp2TxEvt; // R10
		evtVec[vtp_pkg::BIT_EXT3] = pinFall[3]; // R6
		evtVec[vtp_pkg::BIT_HOST] = hostEvt; // R16
		evtVec[vtp_pkg::BIT_SP1_RX] = sp1RxEvt; // R11
		evtVec[vtp_pkg::BIT_SP1_TX] = sp1TxEvt; // R12
		evtVec[vtp_pkg::BIT_DMA4] = dma4Evt; // R13
		evtVec[vtp_pkg::BIT_DMA5] = dma5Evt; // R14
	end

	// ------------------------------------------------------------
	// State declarations
	// ------------------------------------------------------------
	vtp_pkg::vtp_state_t              state_q;
	vtp_pkg::vtp_state_t              state_d;
	vtp_pkg::vtp_src_t                src_q;
	vtp_pkg::vtp_src_t                src_d;
	logic [vtp_pkg::BIT_W-1:0]        bit_q;
	logic [vtp_pkg::BIT_W-1:0]        bit_d;
	logic [vtp_pkg::TRAP_W-1:0]       num_q;
	logic [vtp_pkg::TRAP_W-1:0]       num_d;
	logic [vtp_pkg::ADDR_W-1:0]       vec_q;
	logic [vtp_pkg::ADDR_W-1:0]       vec_d;
	logic [vtp_pkg::NUM_MASKABLE-1:0] flags_q;
	logic [vtp_pkg::NUM_MASKABLE-1:0] flags_d;
	logic [vtp_pkg::NUM_MASKABLE-1:0] mask_q;
	logic [vtp_pkg::NUM_MASKABLE-1:0] mask_d;
	logic                             resetPend_q;
	logic                             resetPend_d;
	logic                             nmiPend_q;
	logic                             nmiPend_d;
	logic                             swPend_q;
	logic                             swPend_d;
	logic [vtp_pkg::TRAP_W-1:0]       swNum_q;
	logic [vtp_pkg::TRAP_W-1:0]       swNum_d;

	// ------------------------------------------------------------
	// Maskable selection
	// ------------------------------------------------------------
	vtp_req_if maskSel ();

	// Pending and enabled only; trap order equals priority order
	assign maskSel.req = flags_q & mask_q; // R18

	vtp_prio_enc uEnc (
		.bus (maskSel.enc)
	);

	// ------------------------------------------------------------
	// Candidate choice
	// ------------------------------------------------------------
	logic                       candAny;
	vtp_pkg::vtp_src_t          candSrc;
	logic [vtp_pkg::TRAP_W-1:0] candNum;

	always_comb begin
		candAny = 1'b1;
		candSrc = vtp_pkg::SRC_RESET;
		candNum = vtp_pkg::TRAP_RESET;
		if (resetPend_q) begin
			candSrc = vtp_pkg::SRC_RESET; // R2
			candNum = vtp_pkg::TRAP_RESET; // R2
		end else if (nmiPend_q) begin
			candSrc = vtp_pkg::SRC_NMI; // R16
			candNum = vtp_pkg::TRAP_NMI; // R16
		end else if (swPend_q) begin
			candSrc = vtp_pkg::SRC_SW; // R17
			candNum = swNum_q;
		end else if (intEnable && maskSel.any) begin
			candSrc = vtp_pkg::SRC_MASK;
			candNum = vtp_pkg::TRAP_MASK_BASE
				+ {1'b0, maskSel.idx}; // R18
		end else begin
			candAny = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Offer state machine
	// ------------------------------------------------------------
	logic taken;

	assign taken = (state_q == vtp_pkg::ST_OFFER) && trapAck;

	always_comb begin
		state_d = state_q;
		src_d = src_q;
		bit_d = bit_q;
		num_d = num_q;
		vec_d = vec_q;
		case (state_q)
			vtp_pkg::ST_IDLE: begin
				if (candAny) begin
					state_d = vtp_pkg::ST_OFFER;
					src_d = candSrc;
					bit_d = maskSel.idx;
					num_d = candNum;
					// Base page above, trap times four below
					vec_d = {vecBase,
						candNum, {vtp_pkg::VEC_SHIFT{1'b0}}}; // R1
				end
			end
			vtp_pkg::ST_OFFER: begin
				// Offer stays fixed until taken, even if a higher one arrives
				if (trapAck) begin
					state_d = vtp_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = vtp_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= vtp_pkg::ST_IDLE;
			src_q <= vtp_pkg::SRC_RESET;
			bit_q <= '0;
			num_q <= vtp_pkg::TRAP_RESET;
			vec_q <= '0;
		end else begin
			state_q <= state_d;
			src_q <= src_d;
			bit_q <= bit_d;
			num_q <= num_d;
			vec_q <= vec_d;
		end
	end

	// ------------------------------------------------------------
	// Pending flags and mask
	// ------------------------------------------------------------
	logic [vtp_pkg::NUM_MASKABLE-1:0] ackClr;

	always_comb begin
		ackClr = '0;
		if (taken && (src_q == vtp_pkg::SRC_MASK)) begin
			ackClr[bit_q] = 1'b1;
		end
		// Reset entry discards stale maskable flags; pending NMI and software traps stay
		if (taken && (src_q == vtp_pkg::SRC_RESET)) begin
			ackClr = '1;
		end
	end

	always_comb begin
		// Same bit index in both registers
		flags_d = (flags_q & ~(flagClr | ackClr)) | evtVec; // R15
		mask_d = mask_q;
		if (maskWrEn) begin
			mask_d = maskWrData; // R15
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flags_q <= vtp_pkg::FLAGS_RESET;
			mask_q <= vtp_pkg::MASK_RESET;
		end else begin
			flags_q <= flags_d;
			mask_q <= mask_d;
		end
	end

	// ------------------------------------------------------------
	// Reset, NMI and software trap requests
	// ------------------------------------------------------------
	logic swIsReset;
	logic swIsValid;
	logic swAccept;

	always_comb begin
		swIsReset = swTrapReq && (swTrapNum == vtp_pkg::TRAP_RESET);
		// Reserved numbers have nothing behind them
		swIsValid = (swTrapNum != vtp_pkg::TRAP_RESET)
			&& (swTrapNum < vtp_pkg::TRAP_RSV_LO); // R17
		// One outstanding software trap; extras are dropped
		swAccept = swTrapReq && swIsValid
			&& (!swPend_q || (taken && src_q == vtp_pkg::SRC_SW));
	end

	always_comb begin
		resetPend_d = (resetPend_q
			&& !(taken && src_q == vtp_pkg::SRC_RESET))
			|| softResetReq || swIsReset; // R2
		nmiPend_d = (nmiPend_q
			&& !(taken && src_q == vtp_pkg::SRC_NMI))
			|| pinFall[vtp_pkg::PIN_NMI]; // R16
		swPend_d = (swPend_q
			&& !(taken && src_q == vtp_pkg::SRC_SW)) || swAccept;
		swNum_d = swAccept ? swTrapNum : swNum_q;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			// Hardware reset leaves its own trap waiting
			resetPend_q <= 1'b1; // R2
			nmiPend_q <= 1'b0;
			swPend_q <= 1'b0;
			swNum_q <= vtp_pkg::TRAP_SW_LO;
		end else begin
			resetPend_q <= resetPend_d;
			nmiPend_q <= nmiPend_d;
			swPend_q <= swPend_d;
			swNum_q <= swNum_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign trapReq = (state_q == vtp_pkg::ST_OFFER);
	assign trapNum = num_q;
	// Base is latched with the offer; a later change waits for the next
	assign trapVector = vec_q;
	assign pendingFlags = flags_q;
	assign maskBits = mask_q;

endmodule

// ---- vtp_trap_prioritizer_properties.sv ----
// Port checks for the trap prioritizer
`timescale 1ns/100ps
module vtp_trap_prioritizer_properties (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [3:0]  extLine_n,
	input wire logic        timerEvt,
	input wire logic        sp0RxEvt,
	input wire logic        sp0TxEvt,
	input wire logic        sp1RxEvt,
	input wire logic        sp1TxEvt,
	input wire logic        sp2RxEvt,
	input wire logic        sp2TxEvt,
	input wire logic        hostEvt,
	input wire logic        dma4Evt,
	input wire logic        dma5Evt,
	input wire logic        intEnable,
	input wire logic        maskWrEn,
	input wire logic [13:0] maskWrData,
	input wire logic [8:0]  vecBase,
	input wire logic        trapAck,
	input wire logic        trapReq,
	input wire logic [4:0]  trapNum,
	input wire logic [15:0] trapVector,
	input wire logic [13:0] pendingFlags,
	input wire logic [13:0] maskBits
);
	// ----
	// Checks
	// ----
	logic [13:0] evtVec;
	assign evtVec = {dma5Evt, dma4Evt, sp1TxEvt, sp1RxEvt, hostEvt, 1'h0,
		sp2TxEvt, sp2RxEvt, sp0TxEvt, sp0RxEvt, timerEvt, 3'h0};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_vec;
		trapReq |-> trapVector == {vecBase, trapNum, 2'h0};
	endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_hold;
		trapReq && !trapAck |=> trapReq && $stable(trapNum);
	endproperty
	a_hold: assert property (p_hold) else $error("offer dropped");
	property p_gap;
		trapReq && trapAck |=> !trapReq;
	endproperty
	a_gap: assert property (p_gap) else $error("no idle gap");
	property p_rst;
		$fell(rst) |-> ##[0:2] (trapReq && trapNum == 5'h00);
	endproperty
	a_rst: assert property (p_rst) else $error("no reset trap");
	// Winner must be enabled and have no enabled lower bit pending
	property p_pick;
		$rose(trapReq) && trapNum[4] |-> $past(intEnable)
			&& ((($past(pendingFlags & maskBits) >> trapNum[3:0])
			& 14'h1) == 14'h1)
			&& ($past(pendingFlags & maskBits)
			& ((14'h1 << trapNum[3:0]) - 14'h1)) == 14'h0;
	endproperty
	a_pick: assert property (p_pick) else $error("bad pick");
	property p_flag;
		!(trapReq && trapAck && trapNum == 5'h00)
			|=> (pendingFlags & $past(evtVec)) == $past(evtVec);
	endproperty
	a_flag: assert property (p_flag) else $error("flag lost");
	property p_mask;
		1'h1 |=> maskBits == $past(maskWrEn ? maskWrData : maskBits);
	endproperty
	a_mask: assert property (p_mask) else $error("bad mask");
	property p_ext;
		$fell(extLine_n[3]) |-> ##[1:5] pendingFlags[8];
	endproperty
	a_ext: assert property (p_ext) else $error("line 3 lost");
	c_rst: cover property (trapReq && trapAck && trapNum == 5'h00);
	c_nmi: cover property (trapReq && trapAck && trapNum == 5'h01);
	c_dma: cover property (trapReq && trapAck && trapNum == 5'h1d);
endmodule
bind vtp_trap_prioritizer vtp_trap_prioritizer_properties u_props (
	.clk_sys, .rst, .extLine_n, .timerEvt, .sp0RxEvt, .sp0TxEvt,
	.sp1RxEvt, .sp1TxEvt, .sp2RxEvt, .sp2TxEvt, .hostEvt, .dma4Evt,
	.dma5Evt, .intEnable, .maskWrEn, .maskWrData, .vecBase, .trapAck,
	.trapReq, .trapNum, .trapVector, .pendingFlags, .maskBits);

// ---- vtp_core_model.sv ----
// Core side: takes each offered trap after a chosen wait
`timescale 1ns/100ps
module vtp_core_model (
	input wire logic       clk_sys,
	input wire logic       trapReq,
	input wire logic [3:0] ackDelay,
	output logic           trapAck
);
	logic [3:0] waitCnt;
	initial begin
		trapAck = 1'h0;
		waitCnt = 4'h0;
	end
	// Ack is a one-cycle pulse, raised only while an offer stands
	always @(posedge clk_sys) begin
		trapAck <= 1'h0;
		if (trapReq && !trapAck) begin
			if (waitCnt >= ackDelay) begin
				trapAck <= 1'h1;
				waitCnt <= 4'h0;
			end else begin
				waitCnt <= waitCnt + 4'h1;
			end
		end
	end
endmodule

// ---- vtp_trap_prioritizer_tb.sv ----
// Self-checking bench for the trap prioritizer
`timescale 1ns/100ps
module vtp_trap_prioritizer_tb;
	logic        clk_sys = 1'h0;
	logic        rst = 1'h1;
	logic [3:0]  extLine_n = 4'hf;
	logic        nmi_n = 1'h1;
	logic [13:0] evt = 14'h0;
	logic        softResetReq = 1'h0;
	logic        swTrapReq = 1'h0;
	logic [4:0]  swTrapNum = 5'h00;
	logic        intEnable = 1'h0;
	logic        maskWrEn = 1'h0;
	logic [13:0] maskWrData = 14'h0;
	logic [13:0] flagClr = 14'h0;
	logic [8:0]  vecBase = 9'h0;
	logic [3:0]  ackDelay = 4'h0;
	logic        trapAck;
	logic        trapReq;
	logic [4:0]  trapNum;
	logic [15:0] trapVector;
	logic [13:0] pendingFlags;
	logic [13:0] maskBits;
	logic [31:0] seed = 32'h9a92;
	logic [20:0] q[$];
	int          err_total = 0;
	int          num_checks = 0;
	int          k;
	always #20 clk_sys = ~clk_sys;
	// ----
	// Design and core
	// ----
	vtp_trap_prioritizer dut (.clk_sys(clk_sys), .rst(rst),
		.extLine_n(extLine_n), .nmi_n(nmi_n), .timerEvt(evt[3]),
		.sp0RxEvt(evt[4]), .sp0TxEvt(evt[5]), .sp2RxEvt(evt[6]),
		.sp2TxEvt(evt[7]), .hostEvt(evt[9]), .sp1RxEvt(evt[10]),
		.sp1TxEvt(evt[11]), .dma4Evt(evt[12]), .dma5Evt(evt[13]),
		.softResetReq(softResetReq), .swTrapReq(swTrapReq),
		.swTrapNum(swTrapNum), .intEnable(intEnable),
		.maskWrEn(maskWrEn), .maskWrData(maskWrData), .flagClr(flagClr),
		.vecBase(vecBase), .trapAck(trapAck), .trapReq(trapReq),
		.trapNum(trapNum), .trapVector(trapVector),
		.pendingFlags(pendingFlags), .maskBits(maskBits));
	vtp_core_model core (.clk_sys(clk_sys), .trapReq(trapReq),
		.ackDelay(ackDelay), .trapAck(trapAck));
	always @(posedge clk_sys) if (trapReq && trapAck)
		q.push_back({trapNum, trapVector});
	// ----
	// Helpers
	// ----
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] vecOf(input logic [4:0] n);
		return {vecBase, 7'h0} + {9'h0, n, 2'h0};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic expectTrap(input logic [4:0] n);
		int i;
		for (i = 0; i < 300 && q.size() == 0; i++) @(posedge clk_sys);
		if (q.size() == 0) begin
			check(16'h0, 16'h1, "trap wait");
			complete_run();
		end else begin
			check({11'h0, q[0][20:16]}, {11'h0, n}, "trap number");
			check(q[0][15:0], vecOf(n), "trap vector");
			void'(q.pop_front());
		end
	endtask
	task automatic expectNone(input int n);
		repeat (n) @(posedge clk_sys);
		check({15'h0, trapReq}, 16'h0, "idle offer");
		check(16'(q.size()), 16'h0, "extra traps");
	endtask
	task automatic fire(input logic [13:0] m);
		@(posedge clk_sys);
		evt <= m & 14'h3ef8;
		extLine_n <= ~{m[8], m[2], m[1], m[0]};
		@(posedge clk_sys);
		evt <= 14'h0;
		repeat (3) @(posedge clk_sys);
		extLine_n <= 4'hf;
	endtask
	task automatic setMask(input logic [13:0] m);
		@(posedge clk_sys);
		maskWrEn <= 1'h1;
		maskWrData <= m;
		@(posedge clk_sys);
		maskWrEn <= 1'h0;
	endtask
	task automatic swTrap(input logic [4:0] n);
		@(posedge clk_sys);
		swTrapReq <= 1'h1;
		swTrapNum <= n;
		@(posedge clk_sys);
		swTrapReq <= 1'h0;
	endtask
	// ----
	// Scenarios
	// ----
	initial begin
		vecBase <= seed[8:0];
		repeat (5) @(posedge clk_sys);
		check({2'h0, pendingFlags | maskBits}, 16'h0, "reset regs");
		rst <= 1'h0;
		expectTrap(5'h00);
		setMask(14'h3fff);
		intEnable <= 1'h1;
		for (k = 0; k < 14; k++) begin
			seed = lfsr(seed);
			ackDelay <= seed[3:0];
			fire(14'h1 << k);
			expectTrap(5'h10 + k[4:0]);
		end
		for (int r = 0; r < 4; r++) begin
			seed = lfsr(seed);
			ackDelay <= seed[7:4];
			setMask(seed[29:16]);
			fire(14'h3ef8);
			for (int j = 0; j < 14; j++)
				if (seed[16 + j] && j != 8 && j > 2) expectTrap(5'h10 + j[4:0]);
			expectNone(6);
			check({2'h0, pendingFlags}, {2'h0, 14'h3ef8 & ~seed[29:16]}, "held");
			flagClr <= 14'h3fff;
			@(posedge clk_sys);
			flagClr <= 14'h0;
		end
		setMask(14'h3fff);
		intEnable <= 1'h0;
		nmi_n <= 1'h0;
		fire(14'h8);
		nmi_n <= 1'h1;
		expectTrap(5'h01);
		expectNone(6);
		intEnable <= 1'h1;
		expectTrap(5'h13);
		for (k = 2; k < 16; k++) begin
			swTrap(k[4:0]);
			expectTrap(k[4:0]);
		end
		swTrap(5'h1e);
		expectNone(6);
		swTrap(5'h1f);
		expectNone(6);
		intEnable <= 1'h0;
		fire(14'h2000);
		softResetReq <= 1'h1;
		@(posedge clk_sys);
		softResetReq <= 1'h0;
		expectTrap(5'h00);
		intEnable <= 1'h1;
		expectNone(6);
		check({2'h0, maskBits}, 16'h3fff, "mask kept");
		swTrap(5'h00);
		expectTrap(5'h00);
		complete_run();
	end
endmodule
